// ==== rtl/pbm_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pbm_map.svh"

module pbm_fifo #(
	parameter int WIDTH = `PBM_WORD,
	parameter int DEPTH = `PBM_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW-1:0] ONE_A = AW'(1);
	localparam logic [CW-1:0] ONE_C = CW'(1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} pbm_fifo_ptr_type;

	pbm_fifo_ptr_type s_reg;
	pbm_fifo_ptr_type s_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// Full and empty come straight from the count, so the source sees true back-pressure
	assign in_ready  = s_reg.cnt != FULL;
	assign out_valid = s_reg.cnt != '0;
	assign out_data  = mem[s_reg.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer wrap handles depths that are not powers of two
	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.wr = (s_reg.wr == LAST) ? '0 : s_reg.wr + ONE_A;
		end
		if (pop) begin
			s_next.rd = (s_reg.rd == LAST) ? '0 : s_reg.rd + ONE_A;
		end
		if (push && !pop) begin
			s_next.cnt = s_reg.cnt + ONE_C;
		end else if (pop && !push) begin
			s_next.cnt = s_reg.cnt - ONE_C;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Storage has no reset; the count guards stale words
	always_ff @(posedge clk) begin
		if (push) begin
			mem[s_reg.wr] <= in_data;
		end
	end
endmodule

module pbm_device (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	pbm_if.device                         pbus,
	input  wire logic                     m_valid,
	output logic                          m_ready,
	input  wire logic [`PBM_WORD-1:0]     m_data,
	input  wire logic [`PBM_WORD-1:0]     m_addr,
	output logic                          m_done,
	output logic                          m_abort,
	output logic                          t_wr_valid,
	output logic      [`PBM_WORD-1:0]     t_wr_data,
	input  wire logic [`PBM_WORD-1:0]     t_rd_data,
	input  wire logic [`PBM_IRQ_SRCS-1:0] irq_src,
	output logic      [`PBM_WORD-1:0]     cfg_word
);
	typedef struct packed {
		pbm_pkg::pbm_core_type c;
		logic [`PBM_WORD-1:0]  cfg;
		logic                  chk_addr;
		logic                  chk_data;
		logic                  chk_par;
		logic                  perr;
		logic                  serr;
		logic                  req;
		logic                  req_oe;
		logic                  irq;
		logic                  wr_valid;
		logic [`PBM_WORD-1:0]  wr_data;
		logic                  done;
		logic                  abort;
	} pbm_dev_type;

	pbm_dev_type          s_reg;
	pbm_dev_type          s_next;
	logic                 f_valid;
	logic [`PBM_WORD-1:0] f_data;
	logic                 pop;
	logic [3:0]           cmd;
	logic                 bus_idle;
	logic                 addr_phase;
	logic                 hit_cfg;
	logic                 hit_mem;

	pbm_fifo #(.WIDTH(`PBM_WORD), .DEPTH(`PBM_FIFO_DEPTH)) pbm_fifo_inst (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (m_valid),
		.in_ready  (m_ready),
		.in_data   (m_data),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	// Address-phase decode of a cycle started by the other master
	assign cmd        = pbus.bus.cbe;
	assign bus_idle   = pbus.bus.frame_n && pbus.bus.irdy_n;
	assign addr_phase = !pbus.bus.frame_n && !s_reg.c.frame_prev;
	assign hit_cfg    = pbus.idsel && (cmd == `PBM_CMD_CFGR || cmd == `PBM_CMD_CFGW);
	assign hit_mem    = s_reg.cfg[`PBM_CFG_MEMEN] && (cmd == `PBM_CMD_MEMR || cmd == `PBM_CMD_MEMW)
		&& pbus.bus.ad[`PBM_BASE_MSB:`PBM_BASE_LSB] == s_reg.cfg[`PBM_BASE_MSB:`PBM_BASE_LSB];
	// The head word leaves on completion or on master abort, but stays for a retry
	assign pop        = s_reg.c.st == pbm_pkg::PBM_M_DATA && (!pbus.bus.trdy_n
		|| (pbus.bus.stop_n && pbus.bus.devsel_n && s_reg.c.tmo == `PBM_TMO_LIMIT));

	always_comb begin
		s_next          = s_reg;
		s_next.wr_valid = 1'b0;
		s_next.done     = 1'b0;
		s_next.abort    = 1'b0;
		s_next.perr     = 1'b0;
		s_next.serr     = 1'b0;
		s_next.chk_addr = 1'b0;
		s_next.chk_data = 1'b0;
		s_next.c.frame_prev = !pbus.bus.frame_n;
		s_next.c.par_o  = ^{s_reg.c.ad_o, pbus.bus.cbe}; // As target the lanes are the master's, not ours
		s_next.c.par_oe = s_reg.c.ad_oe;
		if (s_reg.chk_addr && pbus.bus.par != s_reg.chk_par && s_reg.cfg[`PBM_CFG_SERREN]) begin
			s_next.serr = 1'b1;
		end
		if (s_reg.chk_data && pbus.bus.par != s_reg.chk_par && s_reg.cfg[`PBM_CFG_PAREN]) begin
			s_next.perr = 1'b1;
		end
		s_next.req    = f_valid;
		s_next.req_oe = 1'b1;
		s_next.irq    = |(irq_src & s_reg.cfg[`PBM_CFG_IRQ_MSB:`PBM_CFG_IRQ_LSB]);
		case (s_reg.c.st)
			pbm_pkg::PBM_IDLE: begin
				s_next.c.ad_oe  = 1'b0;
				s_next.c.cbe_oe = 1'b0;
				s_next.c.ctl_oe = 1'b0;
				s_next.c.tgt_oe = 1'b0;
				if (addr_phase) begin
					s_next.chk_addr = 1'b1;
					s_next.chk_par  = ^{pbus.bus.ad, pbus.bus.cbe};
					if (hit_cfg || hit_mem) begin
						s_next.c.st      = pbm_pkg::PBM_T_DATA;
						s_next.c.is_cfg  = hit_cfg;
						s_next.c.is_read = cmd == `PBM_CMD_CFGR || cmd == `PBM_CMD_MEMR;
						s_next.c.tgt_oe  = 1'b1;
						s_next.c.devsel  = 1'b1;
						// Ready at once; STOP keeps each access to one word
						s_next.c.trdy    = 1'b1;
						s_next.c.stop    = 1'b1;
						s_next.c.ad_o    = hit_cfg ? s_reg.cfg : t_rd_data;
						s_next.c.ad_oe   = cmd == `PBM_CMD_CFGR || cmd == `PBM_CMD_MEMR;
					end
				end else if (f_valid && !pbus.gnt_n && bus_idle) begin
					s_next.c.st     = pbm_pkg::PBM_M_ADDR;
					s_next.c.frame  = 1'b1;
					s_next.c.ctl_oe = 1'b1;
					s_next.c.ad_o   = m_addr;
					s_next.c.cbe_o  = `PBM_CMD_MEMW;
					s_next.c.ad_oe  = 1'b1;
					s_next.c.cbe_oe = 1'b1;
					s_next.c.tmo    = '0;
				end
			end
			pbm_pkg::PBM_T_DATA: begin
				if (!pbus.bus.irdy_n) begin
					if (!s_reg.c.is_read) begin
						s_next.chk_data = 1'b1;
						s_next.chk_par  = ^{pbus.bus.ad, pbus.bus.cbe};
						s_next.wr_valid = !s_reg.c.is_cfg;
						s_next.wr_data  = pbus.bus.ad;
						for (int b = 0; b < `PBM_LANES; b++) begin
							if (s_reg.c.is_cfg && !pbus.bus.cbe[b]) begin
								s_next.cfg[b*`PBM_LANE_W +: `PBM_LANE_W] = pbus.bus.ad[b*`PBM_LANE_W +: `PBM_LANE_W];
							end
						end
					end
					s_next.c.st     = pbm_pkg::PBM_T_TURN;
					s_next.c.devsel = 1'b0;
					s_next.c.trdy   = 1'b0;
					s_next.c.stop   = 1'b0;
					s_next.c.ad_oe  = 1'b0;
				end
			end
			pbm_pkg::PBM_T_TURN: begin
				// Lines were driven high for a cycle before release, so they rise cleanly
				s_next.c.tgt_oe = 1'b0;
				s_next.c.st     = pbm_pkg::PBM_IDLE;
			end
			pbm_pkg::PBM_M_ADDR: begin
				s_next.c.frame = 1'b0;
				s_next.c.irdy  = 1'b1;
				s_next.c.ad_o  = f_data;
				s_next.c.cbe_o = `PBM_BE_ALL;
				s_next.c.st    = pbm_pkg::PBM_M_DATA;
			end
			pbm_pkg::PBM_M_DATA: begin
				if (pbus.bus.devsel_n) begin
					s_next.c.tmo = s_reg.c.tmo + `PBM_TMO_STEP;
				end
				if (!pbus.bus.trdy_n || !pbus.bus.stop_n || pop) begin
					s_next.done     = !pbus.bus.trdy_n;
					s_next.abort    = pop && pbus.bus.trdy_n;
					s_next.c.irdy   = 1'b0;
					s_next.c.ad_oe  = 1'b0;
					s_next.c.cbe_oe = 1'b0;
					s_next.c.st     = pbm_pkg::PBM_M_TURN;
				end
			end
			pbm_pkg::PBM_M_TURN: begin
				s_next.c.ctl_oe = 1'b0;
				s_next.c.st     = pbm_pkg::PBM_IDLE;
			end
			default: begin
				s_next.c.st = pbm_pkg::PBM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg     <= '0;
			s_reg.cfg <= `PBM_CFG_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pbus.dev_o   = '{ad: s_reg.c.ad_o, cbe: s_reg.c.cbe_o, par: s_reg.c.par_o, frame_n: ~s_reg.c.frame,
		irdy_n: ~s_reg.c.irdy, trdy_n: ~s_reg.c.trdy, stop_n: ~s_reg.c.stop, devsel_n: ~s_reg.c.devsel,
		perr_n: ~s_reg.perr};
	assign pbus.dev_oe  = '{ad: s_reg.c.ad_oe, cbe: s_reg.c.cbe_oe, par: s_reg.c.par_oe, ctl: s_reg.c.ctl_oe,
		tgt: s_reg.c.tgt_oe, perr: s_reg.perr};
	assign pbus.req_n_o = ~s_reg.req;
	assign pbus.req_oe  = s_reg.req_oe;
	assign pbus.serr_oe = s_reg.serr;
	assign pbus.inta_oe = s_reg.irq;
	assign m_done       = s_reg.done;
	assign m_abort      = s_reg.abort;
	assign t_wr_valid   = s_reg.wr_valid;
	assign t_wr_data    = s_reg.wr_data;
	assign cfg_word     = s_reg.cfg;
endmodule
`default_nettype wire

// ==== rtl/pbm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pbm_map.svh"
module pbm_host (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	pbm_if.host                       pbus,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire logic                 cmd_write,
	input  wire logic                 cmd_cfg,
	input  wire logic [`PBM_WORD-1:0] cmd_addr,
	input  wire logic [`PBM_WORD-1:0] cmd_data,
	output logic                      rsp_valid,
	output logic                      rsp_err,
	output logic      [`PBM_WORD-1:0] rsp_data,
	output logic                      rx_valid,
	output logic      [`PBM_WORD-1:0] rx_data,
	output logic                      irq,
	output logic                      serr_seen
);
	typedef struct packed {
		pbm_pkg::pbm_core_type c;
		logic                  grant;
		logic                  idsel;
		logic [`PBM_WORD-1:0]  data;
		logic                  rsp_valid;
		logic                  rsp_err;
		logic [`PBM_WORD-1:0]  rsp_data;
		logic                  rx_valid;
		logic [`PBM_WORD-1:0]  rx_data;
	} pbm_host_type;

	pbm_host_type s_reg;
	pbm_host_type s_next;
	logic         bus_idle;
	logic         addr_phase;

	assign bus_idle   = pbus.bus.frame_n && pbus.bus.irdy_n;
	assign addr_phase = !pbus.bus.frame_n && !s_reg.c.frame_prev;
	// Own cycles wait until the grant has been withdrawn for a clock
	assign cmd_ready  = s_reg.c.st == pbm_pkg::PBM_IDLE && !s_reg.grant && bus_idle;

	always_comb begin
		s_next              = s_reg;
		s_next.rsp_valid    = 1'b0;
		s_next.rx_valid     = 1'b0;
		s_next.c.frame_prev = !pbus.bus.frame_n;
		s_next.c.par_o      = ^{s_reg.c.ad_o, s_reg.c.cbe_o};
		s_next.c.par_oe     = s_reg.c.ad_oe;
		// Arbiter grants only while this end has nothing of its own queued
		s_next.grant        = !pbus.req_n && !cmd_valid && s_reg.c.st == pbm_pkg::PBM_IDLE;
		case (s_reg.c.st)
			pbm_pkg::PBM_IDLE: begin
				s_next.c.ad_oe  = 1'b0;
				s_next.c.cbe_oe = 1'b0;
				s_next.c.ctl_oe = 1'b0;
				s_next.c.tgt_oe = 1'b0;
				if (addr_phase && pbus.bus.cbe == `PBM_CMD_MEMW) begin
					// Accept every write from the device master as system memory
					s_next.c.st     = pbm_pkg::PBM_T_DATA;
					s_next.c.tgt_oe = 1'b1;
					s_next.c.devsel = 1'b1;
					s_next.c.trdy   = 1'b1;
					s_next.c.stop   = 1'b1;
				end else if (cmd_valid && cmd_ready) begin
					s_next.c.st      = pbm_pkg::PBM_M_ADDR;
					s_next.c.frame   = 1'b1;
					s_next.c.ctl_oe  = 1'b1;
					s_next.c.ad_o    = cmd_addr;
					s_next.c.ad_oe   = 1'b1;
					s_next.c.cbe_oe  = 1'b1;
					s_next.c.cbe_o   = cmd_cfg ? (cmd_write ? `PBM_CMD_CFGW : `PBM_CMD_CFGR)
						: (cmd_write ? `PBM_CMD_MEMW : `PBM_CMD_MEMR);
					s_next.c.is_read = !cmd_write;
					s_next.idsel     = cmd_cfg;
					s_next.data      = cmd_data;
					s_next.c.tmo     = '0;
				end
			end
			pbm_pkg::PBM_T_DATA: begin
				if (!pbus.bus.irdy_n) begin
					s_next.rx_valid = 1'b1;
					s_next.rx_data  = pbus.bus.ad;
					s_next.c.devsel = 1'b0;
					s_next.c.trdy   = 1'b0;
					s_next.c.stop   = 1'b0;
					s_next.c.st     = pbm_pkg::PBM_T_TURN;
				end
			end
			pbm_pkg::PBM_T_TURN: begin
				s_next.c.tgt_oe = 1'b0;
				s_next.c.st     = pbm_pkg::PBM_IDLE;
			end
			pbm_pkg::PBM_M_ADDR: begin
				// Reads release AD so the target can answer
				s_next.c.frame = 1'b0;
				s_next.c.irdy  = 1'b1;
				s_next.idsel   = 1'b0;
				s_next.c.ad_o  = s_reg.data;
				s_next.c.ad_oe = !s_reg.c.is_read;
				s_next.c.cbe_o = `PBM_BE_ALL;
				s_next.c.st    = pbm_pkg::PBM_M_DATA;
			end
			pbm_pkg::PBM_M_DATA: begin
				if (pbus.bus.devsel_n) begin
					s_next.c.tmo = s_reg.c.tmo + `PBM_TMO_STEP;
				end
				if (!pbus.bus.trdy_n || !pbus.bus.stop_n
					|| (pbus.bus.devsel_n && s_reg.c.tmo == `PBM_TMO_LIMIT)) begin
					s_next.rsp_valid = 1'b1;
					s_next.rsp_err   = pbus.bus.trdy_n;
					s_next.rsp_data  = pbus.bus.ad;
					s_next.c.irdy    = 1'b0;
					s_next.c.ad_oe   = 1'b0;
					s_next.c.cbe_oe  = 1'b0;
					s_next.c.st      = pbm_pkg::PBM_M_TURN;
				end
			end
			pbm_pkg::PBM_M_TURN: begin
				s_next.c.ctl_oe = 1'b0;
				s_next.c.st     = pbm_pkg::PBM_IDLE;
			end
			default: begin
				s_next.c.st = pbm_pkg::PBM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pbus.host_o  = '{ad: s_reg.c.ad_o, cbe: s_reg.c.cbe_o, par: s_reg.c.par_o, frame_n: ~s_reg.c.frame,
		irdy_n: ~s_reg.c.irdy, trdy_n: ~s_reg.c.trdy, stop_n: ~s_reg.c.stop, devsel_n: ~s_reg.c.devsel,
		perr_n: 1'b1};
	assign pbus.host_oe = '{ad: s_reg.c.ad_oe, cbe: s_reg.c.cbe_oe, par: s_reg.c.par_oe, ctl: s_reg.c.ctl_oe,
		tgt: s_reg.c.tgt_oe, perr: 1'b0};
	assign pbus.gnt_n   = ~s_reg.grant;
	assign pbus.idsel   = s_reg.idsel;
	assign rsp_valid    = s_reg.rsp_valid;
	assign rsp_err      = s_reg.rsp_err;
	assign rsp_data     = s_reg.rsp_data;
	assign rx_valid     = s_reg.rx_valid;
	assign rx_data      = s_reg.rx_data;
	assign irq          = !pbus.inta_n;
	assign serr_seen    = !pbus.serr_n;
endmodule
`default_nettype wire

// ==== rtl/pbm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pbm_if;
	pbm_pkg::pbm_bus_type dev_o;
	pbm_pkg::pbm_bus_type host_o;
	pbm_pkg::pbm_bus_type bus;
	pbm_pkg::pbm_oe_type  dev_oe;
	pbm_pkg::pbm_oe_type  host_oe;
	logic                 req_n_o;
	logic                 req_oe;
	logic                 req_n;
	logic                 gnt_n;
	logic                 idsel;
	logic                 serr_oe;
	logic                 serr_n;
	logic                 inta_oe;
	logic                 inta_n;

	// Wire resolution; an undriven line floats high as if pulled up
	assign bus.ad       = dev_oe.ad ? dev_o.ad : (host_oe.ad ? host_o.ad : '1);
	assign bus.cbe      = dev_oe.cbe ? dev_o.cbe : (host_oe.cbe ? host_o.cbe : '1);
	assign bus.par      = dev_oe.par ? dev_o.par : (host_oe.par ? host_o.par : 1'b1);
	assign bus.frame_n  = dev_oe.ctl ? dev_o.frame_n : (host_oe.ctl ? host_o.frame_n : 1'b1);
	assign bus.irdy_n   = dev_oe.ctl ? dev_o.irdy_n : (host_oe.ctl ? host_o.irdy_n : 1'b1);
	assign bus.trdy_n   = dev_oe.tgt ? dev_o.trdy_n : (host_oe.tgt ? host_o.trdy_n : 1'b1);
	assign bus.stop_n   = dev_oe.tgt ? dev_o.stop_n : (host_oe.tgt ? host_o.stop_n : 1'b1);
	assign bus.devsel_n = dev_oe.tgt ? dev_o.devsel_n : (host_oe.tgt ? host_o.devsel_n : 1'b1);
	assign bus.perr_n   = dev_oe.perr ? dev_o.perr_n : (host_oe.perr ? host_o.perr_n : 1'b1);
	assign req_n        = req_oe ? req_n_o : 1'b1;
	// Open-drain lines only ever pull low
	assign serr_n       = ~serr_oe;
	assign inta_n       = ~inta_oe;

	modport device(input bus, gnt_n, idsel, output dev_o, dev_oe, req_n_o, req_oe, serr_oe, inta_oe);
	modport host(input bus, req_n, serr_n, inta_n, output host_o, host_oe, gnt_n, idsel);
endinterface
`default_nettype wire

// ==== rtl/pbm_map.svh ====
`ifndef PBM_MAP_SVH
`define PBM_MAP_SVH
// Bus commands carried on the command lines in the address phase
`define PBM_CMD_MEMR    4'h6
`define PBM_CMD_MEMW    4'h7
`define PBM_CMD_CFGR    4'hA
`define PBM_CMD_CFGW    4'hB
// Byte enables, active low: all four lanes
`define PBM_BE_ALL      4'h0
// Word width and write buffer depth
`define PBM_WORD        32
`define PBM_LANES       4
`define PBM_LANE_W      8
`define PBM_FIFO_DEPTH  16
// Device configuration word layout
`define PBM_CFG_RESET   32'h0000_0000
`define PBM_CFG_PAREN   0
`define PBM_CFG_SERREN  1
`define PBM_CFG_MEMEN   2
`define PBM_CFG_IRQ_LSB 4
`define PBM_CFG_IRQ_MSB 7
`define PBM_BASE_LSB    8
`define PBM_BASE_MSB    31
`define PBM_IRQ_SRCS    4
// Master abort when device-select is still absent after this many data cycles have passed without it
`define PBM_TMO_W       3
`define PBM_TMO_LIMIT   3'h5
`define PBM_TMO_STEP    3'h1
`endif

// ==== rtl/pbm_pkg.sv ====
`include "pbm_map.svh"
package pbm_pkg;
	// Shared three-state bus lines, at bus (active-low) levels
	typedef struct packed {
		logic [`PBM_WORD-1:0]  ad;
		logic [`PBM_LANES-1:0] cbe;
		logic                  par;
		logic                  frame_n;
		logic                  irdy_n;
		logic                  trdy_n;
		logic                  stop_n;
		logic                  devsel_n;
		logic                  perr_n;
	} pbm_bus_type;

	// Output enables: ctl covers frame and irdy, tgt covers trdy, stop and devsel
	typedef struct packed {
		logic ad;
		logic cbe;
		logic par;
		logic ctl;
		logic tgt;
		logic perr;
	} pbm_oe_type;

	typedef enum logic [2:0] {PBM_IDLE, PBM_T_DATA, PBM_T_TURN, PBM_M_ADDR, PBM_M_DATA, PBM_M_TURN} pbm_state_type;

	// Core state common to both ends, signals active high
	typedef struct packed {
		pbm_state_type         st;
		logic [`PBM_WORD-1:0]  ad_o;
		logic [`PBM_LANES-1:0] cbe_o;
		logic                  ad_oe;
		logic                  cbe_oe;
		logic                  par_o;
		logic                  par_oe;
		logic                  frame;
		logic                  irdy;
		logic                  ctl_oe;
		logic                  trdy;
		logic                  stop;
		logic                  devsel;
		logic                  tgt_oe;
		logic                  frame_prev;
		logic                  is_read;
		logic                  is_cfg;
		logic [`PBM_TMO_W-1:0] tmo;
	} pbm_core_type;
endpackage

// ==== test/pbm_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbm_checker (
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire pbm_pkg::pbm_bus_type bus,
	input wire pbm_pkg::pbm_oe_type  dev_oe,
	input wire pbm_pkg::pbm_oe_type  host_oe,
	input wire logic                 req_n,
	input wire logic                 req_oe,
	input wire logic                 gnt_n,
	input wire logic                 idsel,
	input wire logic                 serr_n
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Parity trails its phase by one clock, whoever drove the lines
	a_par_even: assert property ((dev_oe.ad || host_oe.ad) |=> bus.par == ^$past({bus.ad, bus.cbe}))
		else $error("parity line wrong one clock after phase");
	a_cbe_master: assert property (dev_oe.cbe |-> dev_oe.ctl)
		else $error("command lines driven without mastership");
	a_cbe_target: assert property (dev_oe.tgt |-> !dev_oe.cbe)
		else $error("command lines driven while target");
	a_start_grant: assert property (($fell(bus.frame_n) && dev_oe.ctl) |-> !$past(gnt_n) && $past(bus.irdy_n))
		else $error("device started without grant or on busy bus");
	// Checked inside reset, so this one has no disable
	a_req_float: assert property (disable iff (1'h0) !reset_n |-> !req_oe)
		else $error("request line driven during reset");
	a_cfg_idsel: assert property ((dev_oe.tgt && !$past(dev_oe.tgt) && $past(bus.cbe[3:1]) == 3'h5) |-> $past(idsel))
		else $error("config cycle claimed without select");
	a_stop_trdy: assert property ((dev_oe.tgt && !bus.trdy_n) |-> !bus.stop_n && !bus.devsel_n)
		else $error("ready without stop or select");
	a_one_phase: assert property ((dev_oe.tgt && !bus.trdy_n && !bus.irdy_n) |=> bus.trdy_n && bus.devsel_n)
		else $error("target held lines after completed phase");
	a_frame_last: assert property ($fell(bus.frame_n) |=> bus.frame_n && !bus.irdy_n)
		else $error("single word frame shape wrong");
	// Both ends make clean parity here, so no error may ever be flagged
	a_no_error: assert property (bus.perr_n && serr_n)
		else $error("error line asserted on clean bus");
endmodule
`default_nettype wire

// ==== test/pci_bus_master_target_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pci_bus_master_target_port_tb;
	logic        clk = 1'h0, reset_n, m_valid = 1'h0, cmd_valid = 1'h0, cmd_write = 1'h0, cmd_cfg = 1'h0;
	logic        m_ready, m_done, t_wr_valid, cmd_ready, rsp_valid, rsp_err, rx_valid, irq, m_abort, serr_seen;
	logic [31:0] m_data = 32'h0, cmd_addr = 32'h0, cmd_data = 32'h0, t_rd_data = 32'hC3C3_1234;
	logic [31:0] t_wr_data, cfg_word, rsp_data, rx_data, wr_seen;
	logic [3:0]  irq_src = 4'h0;
	logic [31:0] rxq[$];
	int          n_fail = 0, n_compared = 0, n_done = 0, n_bad = 0, i;

	// 200 MHz bus clock
	always #2.5 clk = ~clk;

	pbm_if pif();
	pbm_device pbm_device_inst (.clk(clk), .reset_n(reset_n), .pbus(pif.device), .m_valid(m_valid),
		.m_ready(m_ready), .m_data(m_data), .m_addr(32'h0000_8000), .m_done(m_done), .m_abort(m_abort),
		.t_wr_valid(t_wr_valid), .t_wr_data(t_wr_data), .t_rd_data(t_rd_data), .irq_src(irq_src),
		.cfg_word(cfg_word));
	pbm_host pbm_host_inst (.clk(clk), .reset_n(reset_n), .pbus(pif.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_cfg(cmd_cfg), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
		.rx_valid(rx_valid), .rx_data(rx_data), .irq(irq), .serr_seen(serr_seen));
	pbm_checker pbm_checker_inst (.clk(clk), .reset_n(reset_n), .bus(pif.bus), .dev_oe(pif.dev_oe),
		.host_oe(pif.host_oe), .req_n(pif.req_n), .req_oe(pif.req_oe), .gnt_n(pif.gnt_n), .idsel(pif.idsel),
		.serr_n(pif.serr_n));

	// Record one-cycle pulses on falling edges, so a task resuming on the rising edge sees them settled
	always @(negedge clk) begin
		if (t_wr_valid === 1'h1) wr_seen <= t_wr_data;
		if (rx_valid === 1'h1) rxq.push_back(rx_data);
		if (m_done === 1'h1) n_done++;
		if (m_abort !== 1'h0 || serr_seen !== 1'h0) n_bad++;
	end

	task automatic chk(input logic [31:0] seen, want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic results;
		$display("compared %0d, wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Bounded wait, looked at on falling edges where outputs have settled
	task automatic wait_neg(ref logic flag);
		int k;
		k = 0;
		@(negedge clk);
		while (flag !== 1'h1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		if (k >= 400) begin
			n_fail++;
			results();
		end
	endtask

	// One host transaction; request held until the edge that takes it
	task automatic host_op(input logic wr, cfg, input logic [31:0] addr, data, want, input logic err);
		cmd_valid <= 1'h1;
		cmd_write <= wr;
		cmd_cfg <= cfg;
		cmd_addr <= addr;
		cmd_data <= data;
		wait_neg(cmd_ready);
		@(posedge clk);
		cmd_valid <= 1'h0;
		wait_neg(rsp_valid);
		chk({31'h0, rsp_err}, {31'h0, err});
		if (!wr && !err) chk(rsp_data, want);
		@(posedge clk);
	endtask

	task automatic push(input logic [31:0] d);
		m_valid <= 1'h1;
		m_data <= d;
		wait_neg(m_ready);
		@(posedge clk);
	endtask

	initial begin
		// Scheduled so the falling reset edge reaches every flop at time zero
		reset_n <= 1'h0;
		repeat (3) @(posedge clk);
		chk({31'h0, pif.req_oe}, 32'h0);
		reset_n <= 1'h1;
		@(posedge clk);
		chk(cfg_word, 32'h0);
		$display("test reset done");
		host_op(1'h1, 1'h1, 32'h0, 32'h1234_56F7, 32'h0, 1'h0);
		chk(cfg_word, 32'h1234_56F7);
		host_op(1'h0, 1'h1, 32'h4, 32'h0, 32'h1234_56F7, 1'h0);
		host_op(1'h1, 1'h0, 32'h1234_5610, 32'hA5A5_0F0F, 32'h0, 1'h0);
		chk(wr_seen, 32'hA5A5_0F0F);
		host_op(1'h0, 1'h0, 32'h1234_5620, 32'h0, 32'hC3C3_1234, 1'h0);
		host_op(1'h1, 1'h0, 32'h6543_2100, 32'h1, 32'h0, 1'h1);
		$display("test target cycles done");
		irq_src <= 4'h2;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		irq_src <= 4'h0;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// Drop decode and source enables, keep error reporting on
		host_op(1'h1, 1'h1, 32'h0, 32'h1234_5603, 32'h0, 1'h0);
		irq_src <= 4'hF;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		host_op(1'h1, 1'h0, 32'h1234_5610, 32'h1, 32'h0, 1'h1);
		$display("test enables done");
		// Host keeps requesting, so no grant: the buffer must fill and refuse
		cmd_write <= 1'h0;
		cmd_cfg <= 1'h1;
		cmd_valid <= 1'h1;
		for (i = 0; i < 16; i++) push(32'h0BAD_0000 + i);
		m_data <= 32'h0BAD_0010;
		@(negedge clk);
		chk({31'h0, m_ready}, 32'h0);
		chk(rxq.size(), 32'h0);
		@(posedge clk);
		m_valid <= 1'h0;
		cmd_valid <= 1'h0;
		for (i = 0; i < 400 && rxq.size() < 16; i++) @(posedge clk);
		if (rxq.size() < 16) begin
			n_fail++;
			results();
		end
		repeat (2) @(posedge clk);
		for (i = 0; i < 16; i++) chk(rxq[i], 32'h0BAD_0000 + i);
		chk(n_done, 32'h10);
		chk(n_bad, 32'h0);
		$display("test master drain done");
		results();
	end
endmodule
`default_nettype wire
